// ===== rhgs_pkg.sv
// Constants, field positions and carrier types for the root hub status block.
// Assumes a register request port driven by the controller's PCI decoder.
// Behaviour
// - 32-bit status register at offset 50h.
// - Bit 31 written one clears wake enable.
// - Overcurrent indicator change sets bit 17.
// - Writing one clears bit 17; zero ignored.
// - Bit 16 always reads zero.
// - Global mode: bit 16 powers all ports.
// - Per-port mode: powers only unmasked ports.
// - Bit 15 reads wake enable; enables resume.
// - Wake enable clear: no connect wake-up.
// - Bit 15 written one sets wake enable.
// - Bit 1 reads global overcurrent state.
// - Per-port overcurrent: bit 1 reads zero.
// - Bit 0 reads zero; global power off.
// - Per-port mode: bit 0 unpowers unmasked ports.

// =========================================================================
// Package
package rhgs_pkg;
    localparam int          RHGS_NUM_PORTS  = 4;
    localparam logic [7:0]  RHGS_OFFSET     = 8'h50;
    localparam logic [31:0] RHGS_RESET      = 32'h0000_0000;
    localparam int          RHGS_BIT_LPOFF  = 0;
    localparam int          RHGS_BIT_OCI    = 1;
    localparam int          RHGS_BIT_WAKE   = 15;
    localparam int          RHGS_BIT_LPON   = 16;
    localparam int          RHGS_BIT_OCCHG  = 17;
    localparam int          RHGS_BIT_WCLR   = 31;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rhgs_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } rhgs_rsp_t;

    typedef struct packed {
        logic [RHGS_NUM_PORTS-1:0] set;
        logic [RHGS_NUM_PORTS-1:0] clr;
    } rhgs_pwr_t;
endpackage

// ===== rhgs_root_hub_global_status.sv
// Root hub global status and control register with power commands.
// Assumes requests are single-cycle strobes from the controller decoder
// and that the port state machines consume the power and resume pulses.
`timescale 1ns/1ps

// =========================================================================
// Top
module rhgs_root_hub_global_status
(
    input  wire logic                           i_clk,
    input  wire logic                           i_rst_b,
    input  wire rhgs_pkg::rhgs_req_t            i_req,
    output rhgs_pkg::rhgs_rsp_t                 o_rsp,
    input  wire logic                           i_power_switch_mode,
    input  wire logic [rhgs_pkg::RHGS_NUM_PORTS-1:0] i_per_port_power_mask,
    input  wire logic                           i_overcurrent,
    input  wire logic                           i_oc_per_port,
    input  wire logic                           i_bus_suspended_state,
    input  wire logic [rhgs_pkg::RHGS_NUM_PORTS-1:0] i_port_connect_change,
    output rhgs_pkg::rhgs_pwr_t                 o_pwr,
    output logic                                o_remote_wake_enable,
    output logic                                o_resume_req
);
    import rhgs_pkg::*;

    logic                      wr_hit;
    logic                      oci_r;
    logic                      oci_nxt;
    logic                      oc_change;
    logic                      occhg;
    logic                      wake_r;
    logic [RHGS_NUM_PORTS-1:0] port_sel;
    logic [31:0]               rdata_nxt;

    // =====================================================================
    // Decode
    assign wr_hit = i_req.wr && (i_req.addr == RHGS_OFFSET);

    // Per-port mode reaches only the ports left out of the mask.
    assign port_sel = i_power_switch_mode ? ~i_per_port_power_mask
                                          : {RHGS_NUM_PORTS{1'b1}};

    // =====================================================================
    // Overcurrent indicator and its change flag
    assign oci_nxt   = i_overcurrent && !i_oc_per_port;
    assign oc_change = oci_nxt != oci_r;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            oci_r <= RHGS_RESET[RHGS_BIT_OCI];
        else
            oci_r <= oci_nxt;
    end

    rhgs_sticky u_occhg
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_set   (oc_change),
        .i_clr   (wr_hit && i_req.wdata[RHGS_BIT_OCCHG]),
        .o_flag  (occhg)
    );

    // =====================================================================
    // Remote wake-up enable
    // Clear is checked first, so a write holding both strobes disables.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            wake_r <= RHGS_RESET[RHGS_BIT_WAKE];
        else if (wr_hit && i_req.wdata[RHGS_BIT_WCLR])
            wake_r <= 1'b0;
        else if (wr_hit && i_req.wdata[RHGS_BIT_WAKE])
            wake_r <= 1'b1;
    end

    assign o_remote_wake_enable = wake_r;

    // A connect change during suspend is a resume event only when enabled.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_resume_req <= 1'b0;
        else
            o_resume_req <= wake_r && i_bus_suspended_state
                            && (|i_port_connect_change);
    end

    // =====================================================================
    // Power commands
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_pwr.set <= '0;
            o_pwr.clr <= '0;
        end
        else
        begin
            o_pwr.set <= (wr_hit && i_req.wdata[RHGS_BIT_LPON])
                         ? port_sel : '0;
            o_pwr.clr <= (wr_hit && i_req.wdata[RHGS_BIT_LPOFF])
                         ? port_sel : '0;
        end
    end

    // =====================================================================
    // Read path
    // Reserved bits and all three command-only bits (0, 16 and 31) read zero.
    always_comb
    begin
        rdata_nxt = '0;
        if (i_req.addr == RHGS_OFFSET)
        begin
            rdata_nxt[RHGS_BIT_OCI]   = oci_r;
            rdata_nxt[RHGS_BIT_WAKE]  = wake_r;
            rdata_nxt[RHGS_BIT_OCCHG] = occhg;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_rsp.valid <= 1'b0;
            o_rsp.data  <= RHGS_RESET;
        end
        else
        begin
            o_rsp.valid <= i_req.rd;
            o_rsp.data  <= i_req.rd ? rdata_nxt : RHGS_RESET;
        end
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    property p_cmd_bits_read_zero;
        o_rsp.valid |-> !o_rsp.data[RHGS_BIT_LPON]
                        && !o_rsp.data[RHGS_BIT_LPOFF];
    endproperty
    a_cmd_bits_read_zero: assert property (p_cmd_bits_read_zero)
        else $error("Command bits did not read as zero.");

    property p_wake_clear;
        wr_hit && i_req.wdata[RHGS_BIT_WCLR] |=> !o_remote_wake_enable;
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("Wake enable not cleared by clear strobe.");

    property p_wake_set;
        wr_hit && i_req.wdata[RHGS_BIT_WAKE] && !i_req.wdata[RHGS_BIT_WCLR]
            |=> o_remote_wake_enable;
    endproperty
    a_wake_set: assert property (p_wake_set)
        else $error("Wake enable not set.");

    // The answer carries the enable as it stood at the read edge.
    property p_wake_readback;
        i_req.rd && (i_req.addr == RHGS_OFFSET)
            |=> o_rsp.data[RHGS_BIT_WAKE] == $past(wake_r);
    endproperty
    a_wake_readback: assert property (p_wake_readback)
        else $error("Wake enable not read back.");

    property p_wake_hold;
        !wr_hit |=> $stable(o_remote_wake_enable);
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("Wake enable changed without a write.");

    property p_occhg_set;
        $changed(oci_r) |-> occhg;
    endproperty
    a_occhg_set: assert property (p_occhg_set)
        else $error("Overcurrent change flag missed an edge.");

    property p_occhg_clear;
        wr_hit && i_req.wdata[RHGS_BIT_OCCHG] && !oc_change |=> !occhg;
    endproperty
    a_occhg_clear: assert property (p_occhg_clear)
        else $error("Overcurrent change flag not cleared.");

    property p_occhg_sticky;
        occhg && !wr_hit |=> occhg;
    endproperty
    a_occhg_sticky: assert property (p_occhg_sticky)
        else $error("Overcurrent change flag dropped by itself.");

    property p_power_on;
        wr_hit && i_req.wdata[RHGS_BIT_LPON]
            |=> o_pwr.set == ($past(i_power_switch_mode)
                ? ~$past(i_per_port_power_mask) : {RHGS_NUM_PORTS{1'b1}});
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("Power-on pulse reached wrong ports.");

    property p_power_off;
        wr_hit && i_req.wdata[RHGS_BIT_LPOFF]
            |=> o_pwr.clr == ($past(i_power_switch_mode)
                ? ~$past(i_per_port_power_mask) : {RHGS_NUM_PORTS{1'b1}});
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("Power-off pulse reached wrong ports.");

    property p_no_wake_when_off;
        !o_remote_wake_enable |=> !o_resume_req;
    endproperty
    a_no_wake_when_off: assert property (p_no_wake_when_off)
        else $error("Resume raised with wake enable clear.");

    property p_oci_per_port;
        i_oc_per_port |=> !oci_r;
    endproperty
    a_oci_per_port: assert property (p_oci_per_port)
        else $error("Overcurrent indicator set in per-port mode.");

    c_resume: cover property (o_resume_req);
    c_occhg_clear: cover property (occhg ##1 !occhg);
    c_pp_power: cover property (i_power_switch_mode && (|o_pwr.set));
    c_wake_set: cover property (wr_hit ##1 o_remote_wake_enable);
endmodule

// ===== rhgs_root_hub_global_status_tb.sv
// Self-checking bench for the root hub global status register block.
// Assumes the package and the design files are compiled before this one.
`timescale 1ns/1ps

// =========================================================================
// Bench
module rhgs_root_hub_global_status_tb;
    import rhgs_pkg::*;
    logic      i_clk   = 1'b0;
    logic      i_rst_b = 1'b0;
    rhgs_req_t i_req   = '0;
    rhgs_rsp_t o_rsp;
    rhgs_pwr_t o_pwr;
    logic      mode    = 1'b0;
    logic      oc      = 1'b0;
    logic      ocpp    = 1'b0;
    logic      susp    = 1'b0;
    logic [3:0] mask   = 4'h0;
    logic [3:0] cc     = 4'h0;
    logic      wake;
    logic      resume;
    int        n_mismatch = 0;
    int        tests_run  = 0;

    always #2 i_clk = ~i_clk;

    rhgs_root_hub_global_status dut_u
    (
        .i_clk                 (i_clk),
        .i_rst_b               (i_rst_b),
        .i_req                 (i_req),
        .o_rsp                 (o_rsp),
        .i_power_switch_mode   (mode),
        .i_per_port_power_mask (mask),
        .i_overcurrent         (oc),
        .i_oc_per_port         (ocpp),
        .i_bus_suspended_state (susp),
        .i_port_connect_change (cc),
        .o_pwr                 (o_pwr),
        .o_remote_wake_enable  (wake),
        .o_resume_req          (resume)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Entered at a falling edge; the strobe stands for one rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_req.wr    = 1'b1;
        i_req.addr  = a;
        i_req.wdata = d;
        @(negedge i_clk);
        i_req.wr    = 1'b0;
        i_req.wdata = 32'h0000_0000;
    endtask

    // The answer stands only in the cycle after the read edge.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_req.rd   = 1'b1;
        i_req.addr = a;
        @(negedge i_clk);
        i_req.rd = 1'b0;
        chk(32'(o_rsp.valid), 32'h0000_0001, "no read answer");
        chk(o_rsp.data, exp, "read data");
    endtask

    task automatic t_reset;
        rd_chk(RHGS_OFFSET, RHGS_RESET);
        chk(32'(wake), 32'h0, "wake enable after reset");
        $display("test reset done");
    endtask

    task automatic t_wake;
        wr(RHGS_OFFSET, 32'h0000_8000);
        chk(32'(wake), 32'h1, "wake enable not set");
        rd_chk(RHGS_OFFSET, 32'h0000_8000);
        wr(RHGS_OFFSET, 32'h0000_0000);
        chk(32'(wake), 32'h1, "zero write changed wake");
        @(negedge i_clk);
        wr(8'h54, 32'h8000_0000);
        chk(32'(wake), 32'h1, "unmapped write took effect");
        rd_chk(8'h54, 32'h0000_0000);
        wr(RHGS_OFFSET, 32'h8000_0000);
        chk(32'(wake), 32'h0, "wake enable not cleared");
        $display("test wake done");
    endtask

    task automatic t_resume;
        @(negedge i_clk);
        wr(RHGS_OFFSET, 32'h0000_8000);
        susp = 1'b1;
        cc   = 4'h2;
        @(negedge i_clk);
        chk(32'(resume), 32'h1, "no resume on connect change");
        wr(RHGS_OFFSET, 32'h8000_0000);
        @(negedge i_clk);
        chk(32'(resume), 32'h0, "resume while disabled");
        susp = 1'b0;
        cc   = 4'h0;
        $display("test resume done");
    endtask

    task automatic t_power;
        logic [31:0] dat [5] = '{32'h0001_0000, 32'h0000_0001,
                                 32'h0001_0000, 32'h0000_0001, 32'h0};
        logic [7:0]  exp [5] = '{8'hF0, 8'h0F, 8'hA0, 8'h0C, 8'h00};
        logic [3:0]  msk [5] = '{4'h5, 4'h5, 4'h5, 4'h3, 4'h0};
        logic        md  [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++)
        begin
            mode = md[i];
            mask = msk[i];
            wr(RHGS_OFFSET, dat[i]);
            chk(32'(o_pwr.set), 32'(exp[i][7:4]), "on");
            chk(32'(o_pwr.clr), 32'(exp[i][3:0]), "off");
            @(negedge i_clk);
            chk(32'(o_pwr), 32'h0, "power pulse too long");
        end
        $display("test power done");
    endtask

    task automatic t_overcurrent;
        oc = 1'b1;
        repeat (3) @(negedge i_clk);
        rd_chk(RHGS_OFFSET, 32'h0002_0002);
        wr(RHGS_OFFSET, 32'h0000_0000);
        rd_chk(RHGS_OFFSET, 32'h0002_0002);
        wr(RHGS_OFFSET, 32'h0002_0000);
        rd_chk(RHGS_OFFSET, 32'h0000_0002);
        oc = 1'b0;
        repeat (3) @(negedge i_clk);
        rd_chk(RHGS_OFFSET, 32'h0002_0000);
        wr(RHGS_OFFSET, 32'h0002_0000);
        ocpp = 1'b1;
        oc   = 1'b1;
        repeat (3) @(negedge i_clk);
        rd_chk(RHGS_OFFSET, 32'h0000_0000);
        $display("test overcurrent done");
    endtask

    task automatic close_out;
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(negedge i_clk);
        i_rst_b = 1'b1;
        t_reset();
        t_wake();
        t_resume();
        t_power();
        t_overcurrent();
        close_out();
    end

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #20000;
        n_mismatch++;
        close_out();
    end
endmodule

// ===== rhgs_sticky.sv
// Sticky event flag: hardware sets, software clears.
// Assumes both strobes are synchronous to i_clk.
`timescale 1ns/1ps

// =========================================================================
// Sticky flag
module rhgs_sticky
(
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);
    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_flag <= 1'b0;
        else if (i_set)
            o_flag <= 1'b1;
        else if (i_clr)
            o_flag <= 1'b0;
    end
endmodule
